// File: src/acr_pkg.sv
package acr_pkg;
  // Register offsets, page 0
  localparam logic [7:0] OffPageSelect      = 8'h00;
  localparam logic [7:0] OffSoftReset       = 8'h01;
  localparam logic [7:0] OffMiscConfig      = 8'h02;
  localparam logic [7:0] OffSupplyStatus    = 8'h03;
  localparam logic [7:0] OffOut2Config1     = 8'h6c;
  localparam logic [7:0] OffOut2Config2     = 8'h6d;
  localparam logic [7:0] OffCh2aConfig0     = 8'h6e;
  localparam logic [7:0] OffCh2aConfig1     = 8'h6f;
  localparam logic [7:0] OffCh2bConfig0     = 8'h70;
  localparam logic [7:0] OffCh2bConfig1     = 8'h71;
  localparam logic [7:0] OffProcConfig0     = 8'h72;
  localparam logic [7:0] OffProcConfig1     = 8'h73;
  localparam logic [7:0] OffChannelEnable   = 8'h76;
  localparam logic [7:0] OffDynPowerConfig  = 8'h77;
  localparam logic [7:0] OffPowerConfig     = 8'h78;
  localparam logic [7:0] OffDeviceStatus0   = 8'h79;
  localparam logic [7:0] OffDeviceStatus1   = 8'h7a;
  localparam logic [7:0] OffBusChecksum     = 8'h7e;
  localparam logic [7:0] PageZero           = 8'h00;

  // Reset values
  localparam logic [7:0] RstZero            = 8'h00;
  localparam logic [7:0] RstOut2Config      = 8'h20;
  localparam logic [7:0] RstChConfig0       = 8'hc9;
  localparam logic [7:0] RstChConfig1       = 8'h80;
  localparam logic [7:0] RstProcConfig      = 8'h18;
  localparam logic [7:0] RstChannelEnable   = 8'hcc;
  localparam logic [7:0] RstDeviceStatus1   = 8'h80;

  // Writable masks; reserved bits read zero
  localparam logic [7:0] MaskSoftReset      = 8'h01;
  localparam logic [7:0] MaskMiscConfig     = 8'h3f;
  localparam logic [7:0] MaskSupplyStatus   = 8'h01;

  // Field positions
  localparam int BitSoftReset      = 0;
  localparam int BitAwake          = 0;
  localparam int BitIoMode         = 1;
  localparam int BitAnalogMode     = 2;
  localparam int BitExitRef        = 3;
  localparam int BitQchgLo         = 4;
  localparam int BitQchgHi         = 5;
  localparam int BitBrownWake      = 0;
  localparam int BitBrownFlag      = 1;
  localparam int BitIoOverride     = 6;
  localparam int BitAnalogOverride = 7;

  // Quick-charge times in microseconds, by code
  localparam int ClockHz     = 20000000;
  localparam int QchgTime0Us = 3500;
  localparam int QchgTime1Us = 10000;
  localparam int QchgTime2Us = 50000;
  localparam int QchgTime3Us = 100000;
  localparam int QchgCycles0 = QchgTime0Us * (ClockHz / 1000000);
  localparam int QchgCycles1 = QchgTime1Us * (ClockHz / 1000000);
  localparam int QchgCycles2 = QchgTime2Us * (ClockHz / 1000000);
  localparam int QchgCycles3 = QchgTime3Us * (ClockHz / 1000000);

  // Power sequencer states
  typedef enum logic [2:0] {
    PWR_SLEEP  = 3'b001,
    PWR_CHARGE = 3'b010,
    PWR_AWAKE  = 3'b100
  } acr_pwr_e;
endpackage : acr_pkg

// File: src/acr_control_regs.sv
`timescale 1ns/1ps
module acr_control_regs #(
  parameter int unsigned Qchg0Cycles = acr_pkg::QchgCycles0,
  parameter int unsigned Qchg1Cycles = acr_pkg::QchgCycles1,
  parameter int unsigned Qchg2Cycles = acr_pkg::QchgCycles2,
  parameter int unsigned Qchg3Cycles = acr_pkg::QchgCycles3
) (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  // Register access port
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  // Supply detection and brownout events
  input  wire logic       analogSupplyHigh,
  input  wire logic       ioSupplyHigh,
  input  wire logic       brownoutEvent,
  // Power control outputs and active page
  output logic            digitalRegulatorEn,
  output logic            referenceEn,
  output logic            quickChargeActive,
  output logic            analogSupplyMode,
  output logic            ioSupplyMode,
  output logic      [7:0] activePage,
  // Page-0 datapath configuration
  output logic      [7:0] channelEnable,
  output logic      [7:0] powerConfig,
  output logic      [7:0] dynamicPowerConfig
);
  localparam int NumCfg = 14;
  // Generic page-0 registers; the last two (device status 0 and 1) are read-only
  localparam logic [7:0] CfgOff [NumCfg] = '{
    acr_pkg::OffOut2Config1, acr_pkg::OffOut2Config2, acr_pkg::OffCh2aConfig0,
    acr_pkg::OffCh2aConfig1, acr_pkg::OffCh2bConfig0, acr_pkg::OffCh2bConfig1,
    acr_pkg::OffProcConfig0, acr_pkg::OffProcConfig1, acr_pkg::OffChannelEnable,
    acr_pkg::OffDynPowerConfig, acr_pkg::OffPowerConfig, acr_pkg::OffBusChecksum,
    acr_pkg::OffDeviceStatus0, acr_pkg::OffDeviceStatus1};
  localparam logic [7:0] CfgRst [NumCfg] = '{
    acr_pkg::RstOut2Config, acr_pkg::RstOut2Config, acr_pkg::RstChConfig0,
    acr_pkg::RstChConfig1, acr_pkg::RstChConfig0, acr_pkg::RstChConfig1,
    acr_pkg::RstProcConfig, acr_pkg::RstProcConfig, acr_pkg::RstChannelEnable,
    acr_pkg::RstZero, acr_pkg::RstZero, acr_pkg::RstZero,
    acr_pkg::RstZero, acr_pkg::RstDeviceStatus1};
  localparam int NumRw = 12;
  localparam int IdxChEn = 8;
  localparam int IdxDyn = 9;
  localparam int IdxPwr = 10;

  logic [7:0]        pageReg, pageNext;
  logic              softResetReg, softResetNext;
  logic [7:0]        miscReg, miscNext;
  logic              brownWakeReg, brownWakeNext;
  logic              brownFlagReg, brownFlagNext;
  logic              analogOvrReg, analogOvrNext;
  logic              ioOvrReg, ioOvrNext;
  logic [7:0]        cfgReg [NumCfg];
  logic [7:0]        cfgNext [NumCfg];
  logic              onPageZero;
  logic              wrPageZero;
  logic              clearAll;
  acr_pkg::acr_pwr_e pwrReg, pwrNext;
  logic [31:0]       chargeCntReg, chargeCntNext;
  logic [31:0]       chargeLen;
  logic              awake;

  assign onPageZero = (pageReg == acr_pkg::PageZero);
  assign wrPageZero = regWrite && onPageZero;
  assign clearAll = rst || softResetReg;

  // Page, control and status registers next values
  always_comb begin
    pageNext      = pageReg;
    softResetNext = 1'b0;
    miscNext      = miscReg;
    brownWakeNext = brownWakeReg;
    brownFlagNext = brownFlagReg || brownoutEvent;
    analogOvrNext = analogSupplyHigh;
    ioOvrNext     = ioSupplyHigh;
    if (regWrite && regAddr == acr_pkg::OffPageSelect) begin
      pageNext = regWdata;
    end
    if (wrPageZero && regAddr == acr_pkg::OffSoftReset) begin
      softResetNext = regWdata[acr_pkg::BitSoftReset];
    end
    if (wrPageZero && regAddr == acr_pkg::OffMiscConfig) begin
      miscNext = regWdata & acr_pkg::MaskMiscConfig;
    end
    if (wrPageZero && regAddr == acr_pkg::OffSupplyStatus) begin
      brownWakeNext = regWdata[acr_pkg::BitBrownWake];
    end
    // Brownout shutdown leaves the device asleep or awake as selected; beats a host write
    if (brownoutEvent) begin
      miscNext[acr_pkg::BitAwake] = brownWakeReg;
    end
  end

  // Page, control and status registers
  always_ff @(posedge clk) begin
    if (clearAll) begin
      pageReg      <= acr_pkg::PageZero;
      softResetReg <= 1'b0;
      miscReg      <= acr_pkg::RstZero;
      brownWakeReg <= 1'b0;
      brownFlagReg <= 1'b0;
      analogOvrReg <= 1'b0;
      ioOvrReg     <= 1'b0;
    end else if (clkEn) begin
      pageReg      <= pageNext;
      softResetReg <= softResetNext;
      miscReg      <= miscNext;
      brownWakeReg <= brownWakeNext;
      brownFlagReg <= brownFlagNext;
      analogOvrReg <= analogOvrNext;
      ioOvrReg     <= ioOvrNext;
    end
  end

  // Plain page-0 storage, one register per entry
  genvar gi;
  generate
    for (gi = 0; gi < NumCfg; gi++) begin : gCfg
      always_comb begin
        cfgNext[gi] = cfgReg[gi];
        if (gi < NumRw && wrPageZero && regAddr == CfgOff[gi]) begin
          cfgNext[gi] = regWdata;
        end
      end
      always_ff @(posedge clk) begin
        if (clearAll) begin
          cfgReg[gi] <= CfgRst[gi];
        end else if (clkEn) begin
          cfgReg[gi] <= cfgNext[gi];
        end
      end
    end
  endgenerate

  // Quick-charge length from the selected code
  always_comb begin
    case (miscReg[acr_pkg::BitQchgHi:acr_pkg::BitQchgLo])
      2'd0:    chargeLen = Qchg0Cycles;
      2'd1:    chargeLen = Qchg1Cycles;
      2'd2:    chargeLen = Qchg2Cycles;
      default: chargeLen = Qchg3Cycles;
    endcase
  end

  assign awake = miscReg[acr_pkg::BitAwake];

  // Sleep sequencer next state
  always_comb begin
    pwrNext       = pwrReg;
    chargeCntNext = chargeCntReg;
    case (pwrReg)
      acr_pkg::PWR_SLEEP: begin
        chargeCntNext = 32'd0;
        if (awake) begin
          pwrNext = acr_pkg::PWR_CHARGE;
        end
      end
      acr_pkg::PWR_CHARGE: begin
        chargeCntNext = chargeCntReg + 32'd1;
        if (!awake) begin
          pwrNext = acr_pkg::PWR_SLEEP;
        end else if (chargeCntReg + 32'd1 >= chargeLen) begin
          pwrNext = acr_pkg::PWR_AWAKE;
        end
      end
      acr_pkg::PWR_AWAKE: begin
        if (!awake) begin
          pwrNext = acr_pkg::PWR_SLEEP;
        end
      end
      default: pwrNext = acr_pkg::PWR_SLEEP;
    endcase
  end

  // Sleep sequencer state
  always_ff @(posedge clk) begin
    if (clearAll) begin
      pwrReg       <= acr_pkg::PWR_SLEEP;
      chargeCntReg <= 32'd0;
    end else if (clkEn) begin
      pwrReg       <= pwrNext;
      chargeCntReg <= chargeCntNext;
    end
  end

  // Power, page and configuration outputs; detected 3.3V forces mode bits to zero
  assign digitalRegulatorEn = (pwrReg != acr_pkg::PWR_SLEEP);
  assign referenceEn = digitalRegulatorEn && miscReg[acr_pkg::BitExitRef];
  assign quickChargeActive = (pwrReg == acr_pkg::PWR_CHARGE) && referenceEn;
  assign analogSupplyMode = miscReg[acr_pkg::BitAnalogMode] && !analogOvrReg;
  assign ioSupplyMode = miscReg[acr_pkg::BitIoMode] && !ioOvrReg;
  assign activePage = pageReg;
  assign channelEnable = cfgReg[IdxChEn];
  assign dynamicPowerConfig = cfgReg[IdxDyn];
  assign powerConfig = cfgReg[IdxPwr];

  // Read mux; unmapped offsets and other pages read zero, except page select on every page
  always_comb begin
    regRdata = 8'h00;
    if (regRead) begin
      if (regAddr == acr_pkg::OffPageSelect) begin
        regRdata = pageReg;
      end else if (onPageZero) begin
        case (regAddr)
          acr_pkg::OffSoftReset: regRdata = {7'h00, softResetReg} & acr_pkg::MaskSoftReset;
          acr_pkg::OffMiscConfig: regRdata = miscReg & acr_pkg::MaskMiscConfig;
          acr_pkg::OffSupplyStatus: begin
            regRdata[acr_pkg::BitAnalogOverride] = analogOvrReg;
            regRdata[acr_pkg::BitIoOverride]     = ioOvrReg;
            regRdata[acr_pkg::BitBrownFlag]      = brownFlagReg;
            regRdata[acr_pkg::BitBrownWake]      = brownWakeReg;
          end
          default: begin
            for (int i = 0; i < NumCfg; i++) begin
              if (regAddr == CfgOff[i]) begin
                regRdata = cfgReg[i];
              end
            end
          end
        endcase
      end
    end
  end
endmodule : acr_control_regs

// File: verification/acr_control_regs_assertions.sv
`timescale 1ns/1ps
// Port-level checks of the page-0 register bank
module acr_control_regs_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       clkEn,
  // Register access and detectors
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       analogSupplyHigh,
  input wire logic       ioSupplyHigh,
  // Outputs
  input wire logic       digitalRegulatorEn,
  input wire logic       referenceEn,
  input wire logic       quickChargeActive,
  input wire logic [7:0] activePage,
  input wire logic [7:0] channelEnable,
  input wire logic [7:0] powerConfig
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_page_write:
    assert property (regWrite && clkEn && regAddr == 8'h00 |=> activePage == $past(regWdata))
    else $error("page select missed a write");
  a_soft_reset:
    assert property (regWrite && clkEn && activePage == 8'h00 && regAddr == 8'h01 && regWdata[0]
      |=> ##1 (channelEnable == 8'hcc && powerConfig == 8'h00 && activePage == 8'h00))
    else $error("soft reset did not restore defaults");
  a_reset_clears:
    assert property (regRead && activePage == 8'h00 && regAddr == 8'h01 && !$past(regWrite) |-> regRdata == 8'h00)
    else $error("soft reset bit reads set");
  a_ref_needs_reg:
    assert property (referenceEn |-> digitalRegulatorEn)
    else $error("reference on without regulator");
  a_charge_ref:
    assert property (quickChargeActive |-> referenceEn)
    else $error("quick charge without reference");
  a_analog_flag:
    assert property (regRead && activePage == 8'h00 && regAddr == 8'h03 && $past(clkEn) && !$past(rst)
      |-> regRdata[7] == $past(analogSupplyHigh))
    else $error("analog override flag wrong");
  a_io_flag:
    assert property (regRead && activePage == 8'h00 && regAddr == 8'h03 && $past(clkEn) && !$past(rst)
      |-> regRdata[6] == $past(ioSupplyHigh))
    else $error("io override flag wrong");
  a_status_one:
    assert property (regRead && activePage == 8'h00 && regAddr == 8'h7a |-> regRdata == 8'h80)
    else $error("status one value wrong");
  a_unmapped_zero:
    assert property (regRead && regAddr inside {8'h74, 8'h7b, 8'h7c, 8'h7d} |-> regRdata == 8'h00)
    else $error("unmapped offset read nonzero");
  a_page_gate:
    assert property (regRead && activePage != 8'h00 && regAddr != 8'h00 |-> regRdata == 8'h00)
    else $error("other page read nonzero");
endmodule : acr_control_regs_assertions

// File: verification/acr_host_model.sv
`timescale 1ns/1ps
// Host side of the register port, one byte per access
module acr_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  // Idle port at time zero
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end

  // Write strobe for one edge; reserved positions carry zero
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= addr;
    regWdata <= (addr == 8'h02) ? data & 8'h3f : (addr inside {8'h01, 8'h03}) ? data & 8'h01 : data;
    @(posedge clk);
    regWrite <= 1'b0;
    regWdata <= ~data;
  endtask : wr

  // Read held until the next rising edge, data taken at that edge
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= addr;
    @(posedge clk);
    data = regRdata;
    regRead <= 1'b0;
  endtask : rd
endmodule : acr_host_model

// File: verification/acr_control_regs_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the page-0 control registers
module acr_control_regs_bench;
  logic       clk, rst, clkEn, analogSupplyHigh, ioSupplyHigh, brownoutEvent, regWrite, regRead;
  logic       digitalRegulatorEn, referenceEn, quickChargeActive, analogSupplyMode, ioSupplyMode;
  logic [7:0] regAddr, regWdata, regRdata, activePage, channelEnable, powerConfig, dynamicPowerConfig, rd, v;
  int         mismatches, compares, n;
  localparam int unsigned Q [4] = '{4, 6, 8, 10};
  logic [7:0] defAddrs [$] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h71,
                              8'h72, 8'h73, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7e, 8'h74, 8'h7b};

  acr_control_regs #(.Qchg0Cycles(Q[0]), .Qchg1Cycles(Q[1]), .Qchg2Cycles(Q[2]), .Qchg3Cycles(Q[3])) dut (
    .clk, .rst, .clkEn, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .analogSupplyHigh,
    .ioSupplyHigh, .brownoutEvent, .digitalRegulatorEn, .referenceEn, .quickChargeActive,
    .analogSupplyMode, .ioSupplyMode, .activePage, .channelEnable, .powerConfig, .dynamicPowerConfig);
  acr_host_model host (.clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata);

  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Documented reset value of each offset
  function automatic logic [7:0] rstval(input logic [7:0] a);
    case (a)
      8'h6c, 8'h6d:        rstval = 8'h20;
      8'h6e, 8'h70:        rstval = 8'hc9;
      8'h6f, 8'h71, 8'h7a: rstval = 8'h80;
      8'h72, 8'h73:        rstval = 8'h18;
      8'h76:               rstval = 8'hcc;
      default:             rstval = 8'h00;
    endcase
  endfunction : rstval

  // Byte comparison with counting
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Reads every listed offset against its default
  task automatic check_defaults;
    foreach (defAddrs[i]) begin
      host.rd(defAddrs[i], rd);
      chk(rd, rstval(defAddrs[i]));
    end
    // Configuration outputs settle between edges
    @(negedge clk);
    chk(channelEnable, 8'hcc);
    chk(powerConfig, 8'h00);
    chk(dynamicPowerConfig, 8'h00);
    chk(activePage, 8'h00);
  endtask : check_defaults

  // Verdict and end of run
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    void'($urandom(18));
    rst = 1'b1;
    clkEn = 1'b1;
    analogSupplyHigh = 1'b0;
    ioSupplyHigh = 1'b0;
    brownoutEvent = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check_defaults();
    $display("test defaults done");
    // Random write and read-back; read-only and unmapped offsets keep their value
    foreach (defAddrs[i]) begin
      v = 8'($urandom);
      if (defAddrs[i] > 8'h03) begin
        host.wr(defAddrs[i], v);
        host.rd(defAddrs[i], rd);
        chk(rd, (defAddrs[i] inside {8'h79, 8'h7a, 8'h74, 8'h7b}) ? rstval(defAddrs[i]) : v);
      end
    end
    $display("test readback done");
    // Top page and a random page hide page 0
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'($urandom_range(254, 1)) : 8'hff;
      host.wr(8'h00, v);
      host.rd(8'h00, rd);
      chk(rd, v);
      host.wr(8'h76, 8'h33);
      host.rd(8'h76, rd);
      chk(rd, 8'h00);
    end
    host.wr(8'h00, 8'h00);
    host.wr(8'h76, 8'h5a);
    host.rd(8'h76, rd);
    chk(rd, 8'h5a);
    $display("test pages done");
    // Wake with reference for every quick-charge code
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h02, 8'h00);
      host.wr(8'h02, {2'b00, 2'(k), 4'b1001});
      n = 0;
      repeat (Q[3] + 4) begin
        @(negedge clk);
        n += int'(quickChargeActive === 1'b1);
      end
      chk(8'(n), 8'(Q[k]));
      chk({6'h00, digitalRegulatorEn, referenceEn}, 8'h03);
    end
    host.wr(8'h02, 8'h01);
    @(negedge clk);
    chk({6'h00, digitalRegulatorEn, referenceEn}, 8'h02);
    host.wr(8'h02, 8'h00);
    repeat (2) @(negedge clk);
    chk({6'h00, digitalRegulatorEn, referenceEn}, 8'h00);
    $display("test sleep done");
    // Direct supply modes at 1.8V, then forced back by 3.3V detection
    host.wr(8'h02, 8'h06);
    @(negedge clk);
    chk({6'h00, analogSupplyMode, ioSupplyMode}, 8'h03);
    @(posedge clk);
    analogSupplyHigh <= 1'b1;
    ioSupplyHigh <= 1'b1;
    repeat (2) @(negedge clk);
    chk({6'h00, analogSupplyMode, ioSupplyMode}, 8'h00);
    host.rd(8'h03, rd);
    chk(rd, 8'hc0);
    analogSupplyHigh <= 1'b0;
    ioSupplyHigh <= 1'b0;
    host.rd(8'h03, rd);
    chk(rd, 8'h00);
    $display("test supply done");
    // Brownout with each wake selection
    for (int w = 0; w < 2; w++) begin
      host.wr(8'h03, 8'(w));
      host.wr(8'h02, 8'(1 - w));
      brownoutEvent <= 1'b1;
      @(posedge clk);
      brownoutEvent <= 1'b0;
      repeat (2) @(negedge clk);
      chk({7'h00, digitalRegulatorEn}, 8'(w));
      host.rd(8'h03, rd);
      chk(rd, 8'(2 + w));
    end
    $display("test brownout done");
    // Soft reset restores everything and clears itself
    host.wr(8'h01, 8'h01);
    host.rd(8'h01, rd);
    chk(rd, 8'h00);
    check_defaults();
    $display("test soft reset done");
    end_sim();
  end

  // Watchdog: the sequence needs under 1500 cycles
  initial begin
    #(3000 * 50);
    mismatches++;
    end_sim();
  end
endmodule : acr_control_regs_bench

bind acr_control_regs acr_control_regs_assertions chk (.clk, .rst, .clkEn, .regWrite, .regRead, .regAddr,
  .regWdata, .regRdata, .analogSupplyHigh, .ioSupplyHigh, .digitalRegulatorEn, .referenceEn,
  .quickChargeActive, .activePage, .channelEnable, .powerConfig);
